/* shared/phtap_pkg.sv */
// Shared constants and types for the delay tap configuration block
package phtap_pkg;

   // ================================================================
   // Sizes
   localparam int NUM_CHANNELS = 5;
   localparam int CODE_W = 5;
   localparam int SEL_W = 3;
   localparam int PIN_ADDR_W = 4;

   // ================================================================
   // Field positions within an address byte and a data byte
   localparam int ADDR_TOP_POS = 7;
   localparam int ADDR_PIN_MSB = 6;
   localparam int ADDR_PIN_LSB = 3;
   localparam int ADDR_RW_POS = 0;
   localparam int SEL_MSB = 7;
   localparam int SEL_LSB = 5;
   localparam int CODE_MSB = 4;

   // ================================================================
   // Bit counts
   localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
   localparam logic [3:0] BIT_CNT_LAST = 4'h7;
   localparam logic [3:0] BIT_CNT_BYTE = 4'h8;

   // ================================================================
   // Tap codes and channel selectors
   localparam logic [4:0] CODE_TAP_MAX = 5'h18;
   localparam logic [4:0] CODE_FORCE_LOW = 5'h19;
   localparam logic [4:0] CODE_PHASE = 5'h1a;
   localparam logic [4:0] CODE_FORCE_HIGH = 5'h1b;
   localparam logic [2:0] SEL_LAST_VALID = 3'h4;
   localparam logic [2:0] SEL_CLOCK_CHANNEL = 3'h4;

   // ================================================================
   // Values after reset
   localparam logic [4:0] TAP_RESET = 5'h00;
   localparam logic [2:0] SEL_RESET = 3'h0;
   localparam logic [7:0] SHIFT_RESET = 8'h00;

   // ================================================================
   // Types
   typedef struct packed {
      logic tap_enable;
      logic [4:0] tap_index;
      logic force_low;
      logic force_high;
      logic phase_route;
   } phtap_mode_s;

   localparam phtap_mode_s MODE_RESET = '0;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ACK,
      ST_WRITE,
      ST_READ,
      ST_SKIP
   } phtap_state_e;

endpackage : phtap_pkg

/* hw/phtap_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module phtap_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // ================================================================
   // Metastability stages
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule : phtap_sync

/* hw/phtap_decode.sv */
// Decoder from a stored tap code to the channel output selection
`timescale 1ns/100ps
module phtap_decode (
   input wire logic [4:0] code,
   output phtap_pkg::phtap_mode_s mode
);

   // ================================================================
   // Code decode; codes above the last defined one switch output off
   always_comb begin
      mode = phtap_pkg::MODE_RESET;
      if (code <= phtap_pkg::CODE_TAP_MAX) begin
         mode.tap_enable = 1'b1; // [R6]
         mode.tap_index = code; // [R6]
      end else if (code == phtap_pkg::CODE_FORCE_LOW) begin
         mode.force_low = 1'b1; // [R7]
      end else if (code == phtap_pkg::CODE_PHASE) begin
         mode.phase_route = 1'b1; // [R8]
      end else if (code == phtap_pkg::CODE_FORCE_HIGH) begin
         mode.force_high = 1'b1; // [R9]
      end
   end

endmodule : phtap_decode

/* hw/phtap_config.sv */
// Two-wire programmed tap configuration for a five-channel delay unit
//
// Contract
// R1: Middle four address bits match address pins
// R2: Top address bit must be zero
// R3: Lowest two address bits are ignored
// R4: Data byte splits into selector and code
// R5: Write is address, ack, byte, nack, stop
// R6: Codes 0 to 24 select that tap
// R7: Code 25 forces output low
// R8: Code 26 routes phase detector output
// R9: Code 27 forces output high
// R10: Selectors 0-3 signal channels, 4 clock
// R11: Each channel holds a 5-bit code register
// R12: First clock falling edge starts internal reset
// R13: First transfer leaves the registers unchanged
// R14: Reference clock must run during reset
// R15: Master issues a dummy transfer after power-up
// R16: Channel registers are writable and readable
// R17: Reference clock must be supplied
// R18: Unmatched address gets no ack, ignored
// R19: Commit after eight bits; selectors 5-7 ignored
`timescale 1ns/100ps
module phtap_config (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic scl_pin,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [3:0] pin_address_bits,
   output logic [4:0][4:0] tap_select,
   output phtap_pkg::phtap_mode_s [4:0] channel_mode,
   output logic device_reset_done
);

   // ================================================================
   // Pin synchronisation
   logic [5:0] pins_q;
   logic scl_q;
   logic sda_q;
   logic [3:0] addr_pins_q;
   logic scl_d;
   logic sda_d;

   phtap_sync #(
      .WIDTH(6)
   ) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .async_in({~scl_pin, ~sda_in, pin_address_bits}),
      .sync_out(pins_q)
   );

   // Bus lines travel inverted so a cleared stage reads as idle high
   assign scl_q = ~pins_q[5];
   assign sda_q = ~pins_q[4];
   assign addr_pins_q = pins_q[3:0];

   // Bus idles high; reset to high avoids a false start
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_q;
         sda_d <= sda_q;
      end
   end

   // ================================================================
   // Bus events
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;

   assign scl_rise = scl_q & ~scl_d;
   assign scl_fall = ~scl_q & scl_d;
   assign start_cond = scl_q & scl_d & sda_d & ~sda_q;
   assign stop_cond = scl_q & scl_d & ~sda_d & sda_q;

   // ================================================================
   // Internal reset trigger
   logic reset_trigger;

   assign reset_trigger = ~device_reset_done & scl_fall; // [R12]

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         device_reset_done <= 1'b0;
      end else if (reset_trigger) begin
         device_reset_done <= 1'b1; // [R12]
      end
   end

   // ================================================================
   // Transfer state
   phtap_pkg::phtap_state_e state;
   logic [3:0] bit_cnt;
   logic [7:0] shift;
   logic read_dir;
   logic addr_match;
   logic [7:0] byte_in;
   logic [2:0] wr_sel;
   logic [4:0] wr_code;
   logic sel_ok;
   logic wr_commit;
   logic addr_done;
   logic ack_done;

   // Only the top bit and the pin bits take part in the compare
   assign addr_match = ~shift[phtap_pkg::ADDR_TOP_POS] // [R2]
      & (shift[phtap_pkg::ADDR_PIN_MSB:phtap_pkg::ADDR_PIN_LSB]
      == addr_pins_q); // [R1] [R3]
   assign byte_in = {shift[6:0], sda_q};
   assign wr_sel = byte_in[phtap_pkg::SEL_MSB:phtap_pkg::SEL_LSB]; // [R4]
   assign wr_code = byte_in[phtap_pkg::CODE_MSB:0]; // [R4]
   assign sel_ok = wr_sel <= phtap_pkg::SEL_LAST_VALID; // [R19]
   assign wr_commit = (state == phtap_pkg::ST_WRITE) & scl_rise
      & (bit_cnt == phtap_pkg::BIT_CNT_LAST) & device_reset_done; // [R19]
   assign addr_done = (state == phtap_pkg::ST_ADDR) & scl_fall
      & (bit_cnt == phtap_pkg::BIT_CNT_BYTE);
   assign ack_done = (state == phtap_pkg::ST_ACK) & scl_fall;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= phtap_pkg::ST_IDLE;
         bit_cnt <= phtap_pkg::BIT_CNT_ZERO;
         shift <= phtap_pkg::SHIFT_RESET;
         read_dir <= 1'b0;
      end else if (reset_trigger) begin
         state <= phtap_pkg::ST_SKIP; // [R13]
      end else if (stop_cond) begin
         state <= phtap_pkg::ST_IDLE;
      end else if (start_cond) begin
         state <= phtap_pkg::ST_ADDR; // [R5]
         bit_cnt <= phtap_pkg::BIT_CNT_ZERO;
      end else begin
         case (state)
            phtap_pkg::ST_ADDR: begin
               if (scl_rise) begin
                  shift <= byte_in;
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (addr_done) begin
                  bit_cnt <= phtap_pkg::BIT_CNT_ZERO;
                  read_dir <= shift[phtap_pkg::ADDR_RW_POS];
                  if (addr_match) begin
                     state <= phtap_pkg::ST_ACK; // [R1]
                  end else begin
                     state <= phtap_pkg::ST_SKIP; // [R18]
                  end
               end
            end
            phtap_pkg::ST_ACK: begin
               if (scl_fall) begin
                  bit_cnt <= phtap_pkg::BIT_CNT_ZERO;
                  if (read_dir) begin
                     state <= phtap_pkg::ST_READ; // [R16]
                  end else begin
                     state <= phtap_pkg::ST_WRITE; // [R5]
                  end
               end
            end
            phtap_pkg::ST_WRITE: begin
               if (scl_rise) begin
                  shift <= byte_in;
                  bit_cnt <= bit_cnt + 4'h1;
                  // Further bytes fall into the skip state unanswered
                  if (bit_cnt == phtap_pkg::BIT_CNT_LAST) begin
                     state <= phtap_pkg::ST_SKIP; // [R5]
                  end
               end
            end
            phtap_pkg::ST_READ: begin
               if (scl_fall) begin
                  if (bit_cnt == phtap_pkg::BIT_CNT_LAST) begin
                     state <= phtap_pkg::ST_SKIP;
                  end else begin
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
            end
            phtap_pkg::ST_IDLE, phtap_pkg::ST_SKIP: begin
               bit_cnt <= bit_cnt;
            end
            default: begin
               state <= phtap_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ================================================================
   // Channel registers and output selection
   logic [2:0] rd_sel;
   logic [7:0] rd_byte;

   genvar ch;
   generate
      for (ch = 0; ch < phtap_pkg::NUM_CHANNELS; ch++) begin : g_chan
         phtap_pkg::phtap_mode_s next_mode;

         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               tap_select[ch] <= phtap_pkg::TAP_RESET;
            end else if (reset_trigger) begin
               tap_select[ch] <= phtap_pkg::TAP_RESET; // [R12]
            end else if (wr_commit && wr_sel == 3'(ch)) begin
               tap_select[ch] <= wr_code; // [R10] [R11]
            end
         end

         phtap_decode u_decode (
            .code(tap_select[ch]),
            .mode(next_mode)
         );

         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               channel_mode[ch] <= phtap_pkg::MODE_RESET;
            end else begin
               channel_mode[ch] <= next_mode; // [R11]
            end
         end

         tap_pass_a: assert property (@(posedge clk) disable iff (!reset_n)
            tap_select[ch] <= phtap_pkg::CODE_TAP_MAX |=> // [R6]
            channel_mode[ch].tap_enable
            && channel_mode[ch].tap_index == $past(tap_select[ch]))
            else $error("tap code not passed to mux");
         low_force_a: assert property (@(posedge clk) disable iff (!reset_n)
            tap_select[ch] == phtap_pkg::CODE_FORCE_LOW |=> // [R7]
            channel_mode[ch].force_low && !channel_mode[ch].tap_enable)
            else $error("force low not applied");
         phase_route_a: assert property (@(posedge clk)
            disable iff (!reset_n) // [R8]
            tap_select[ch] == phtap_pkg::CODE_PHASE |=>
            channel_mode[ch].phase_route && !channel_mode[ch].force_high)
            else $error("phase route not applied");
         high_force_a: assert property (@(posedge clk) disable iff (!reset_n)
            tap_select[ch] == phtap_pkg::CODE_FORCE_HIGH |=> // [R9]
            channel_mode[ch].force_high && !channel_mode[ch].force_low)
            else $error("force high not applied");
      end
   endgenerate

   // Read-back pointer follows the last valid write
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_sel <= phtap_pkg::SEL_RESET;
      end else if (wr_commit && sel_ok) begin
         rd_sel <= wr_sel; // [R16]
      end
   end

   assign rd_byte = {rd_sel, tap_select[rd_sel]}; // [R16]

   // ================================================================
   // Open-drain data line drive
   logic [7:0] rd_shift;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sda_oe <= 1'b0;
         sda_out <= 1'b0;
         rd_shift <= phtap_pkg::SHIFT_RESET;
      end else if (reset_trigger || start_cond || stop_cond) begin
         sda_oe <= 1'b0;
      end else if (addr_done) begin
         sda_oe <= addr_match; // [R1] [R18]
      end else if (ack_done) begin
         // Data bit changes only while the clock is low
         if (read_dir) begin
            sda_oe <= ~rd_byte[7]; // [R16]
            rd_shift <= {rd_byte[6:0], 1'b0};
         end else begin
            sda_oe <= 1'b0;
         end
      end else if (state == phtap_pkg::ST_READ && scl_fall) begin
         if (bit_cnt == phtap_pkg::BIT_CNT_LAST) begin
            sda_oe <= 1'b0;
         end else begin
            sda_oe <= ~rd_shift[7];
            rd_shift <= {rd_shift[6:0], 1'b0};
         end
      end
   end

   // ================================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_addr_hit;
      addr_done && device_reset_done && addr_match;
   endsequence

   sequence s_bad_write;
      wr_commit && !sel_ok;
   endsequence

   addr_ack_a: assert property (s_addr_hit |=> sda_oe // [R1]
      && state == phtap_pkg::ST_ACK)
      else $error("matching address not acknowledged");
   top_bit_a: assert property (addr_done && shift[7] |=> !sda_oe) // [R2]
      else $error("address with top bit set acknowledged");
   dont_care_a: assert property (addr_done && !shift[7] // [R3]
      && shift[6:3] == addr_pins_q |=> sda_oe)
      else $error("low address bits not ignored");
   addr_nack_a: assert property (addr_done && !addr_match |=> // [R18]
      !sda_oe && state == phtap_pkg::ST_SKIP)
      else $error("foreign address not ignored");
   commit_a: assert property (wr_commit && sel_ok |=> // [R4] [R19]
      tap_select[$past(wr_sel)] == $past(wr_code))
      else $error("data byte not committed");
   bad_sel_a: assert property (s_bad_write |=> // [R19]
      $stable(tap_select))
      else $error("invalid selector changed a register");
   first_skip_a: assert property (reset_trigger |=> // [R13]
      state == phtap_pkg::ST_SKIP && tap_select == '0 ##1
      device_reset_done)
      else $error("first transfer not ignored");
   write_nack_a: assert property (state == phtap_pkg::ST_WRITE // [R5]
      |-> !sda_oe)
      else $error("data byte acknowledged on write");
   clock_chan_a: assert property (wr_commit // [R10]
      && wr_sel == phtap_pkg::SEL_CLOCK_CHANNEL |=>
      tap_select[4] == $past(wr_code))
      else $error("clock channel not addressed by selector 4");
   read_first_a: assert property (ack_done && read_dir |=> // [R16]
      sda_oe == !$past(rd_byte[7]))
      else $error("read-back first bit wrong");

endmodule : phtap_config

/* test/phtap_master.sv */
// Bus master model for the two-wire configuration port
`timescale 1ns/100ps
module phtap_master (
   input wire logic sda_wire,
   output logic scl,
   output logic sda_pull
);
   // ==========================================
   // Idle: clock stands high, data released
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // ==========================================
   // One bit; data moves only while clock low
   task automatic put_bit(input logic b, output logic seen);
      #43;
      sda_pull = ~b;
      #42;
      scl = 1'b1;
      #20;
      seen = sda_wire;
      #20;
      scl = 1'b0;
   endtask : put_bit

   // ==========================================
   // Start, address byte, ack, data bits, nack, stop
   task automatic xfer(input logic [7:0] addr, input logic [7:0] data,
         input int nbits, output logic ack, output logic [7:0] rd);
      logic seen;
      rd = 8'hff;
      sda_pull = 1'b1;
      #60;
      scl = 1'b0;
      for (int i = 7; i >= 0; i--) put_bit(addr[i], seen);
      put_bit(1'b1, seen);
      ack = ~seen;
      for (int i = 7; i >= 8 - nbits; i--) begin
         put_bit(addr[0] | data[i], seen);
         rd[i] = seen;
      end
      // Nack only on a whole byte; a short byte ends abruptly
      if (nbits == 8) put_bit(1'b1, seen);
      #43;
      sda_pull = 1'b1;
      #42;
      scl = 1'b1;
      #40;
      sda_pull = 1'b0;
      #125;
   endtask : xfer
endmodule : phtap_master

/* test/tb_top.sv */
// Self-checking bench for the tap configuration block
`timescale 1ns/100ps
module tb_top;
   typedef struct packed {
      logic ack;
      logic [7:0] rd;
      logic [4:0][4:0] taps;
   } phtap_exp_s;

   logic clk, reset_n, scl, sda_pull, sda_out, sda_oe, device_reset_done;
   logic [3:0] pins;
   logic [4:0][4:0] tap_select;
   phtap_pkg::phtap_mode_s [4:0] channel_mode;
   wire logic sda_wire = (sda_oe ? sda_out : 1'b1) & ~sda_pull;
   int num_errors = 0;
   int compares = 0;
   logic [31:0] seed, r;
   logic [4:0][4:0] model;
   logic [2:0] rd_sel, sel;
   logic ack_seen;
   logic [7:0] rd_seen;
   phtap_exp_s exp_q[$];
   event xfer_done;

   phtap_config phtap_config_i (.clk(clk), .reset_n(reset_n),
      .scl_pin(scl), .sda_in(sda_wire), .sda_out(sda_out),
      .sda_oe(sda_oe), .pin_address_bits(pins), .tap_select(tap_select),
      .channel_mode(channel_mode), .device_reset_done(device_reset_done));
   phtap_master phtap_master_i (.sda_wire(sda_wire), .scl(scl),
      .sda_pull(sda_pull));

   // ==========================================
   // Clock keeps running through reset
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ==========================================
   // Reporting
   task automatic check(input string name, input logic [39:0] e,
         input logic [39:0] g);
      compares++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", name, e, g);
         num_errors++;
      end
   endtask : check

   task automatic end_sim();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim

   function automatic phtap_pkg::phtap_mode_s exp_mode(input logic [4:0] c);
      phtap_pkg::phtap_mode_s x;
      x = '0;
      x.tap_enable = c <= 5'h18;
      if (x.tap_enable) x.tap_index = c;
      x.force_low = c == 5'h19;
      x.phase_route = c == 5'h1a;
      x.force_high = c == 5'h1b;
      return x;
   endfunction : exp_mode

   // ==========================================
   // Driver: note the expectation, then run the transfer
   task automatic send(input logic [7:0] addr, input logic [7:0] data,
         input int nbits, input logic live);
      phtap_exp_s e;
      logic ok, ack;
      logic [7:0] rd;
      ok = live && addr[7] == 1'b0 && addr[6:3] == pins;
      e.ack = ok;
      e.rd = (ok || !addr[0]) ? {rd_sel, model[rd_sel]} : 8'hff;
      if (ok && !addr[0] && nbits == 8 && data[7:5] <= 3'h4) begin
         model[data[7:5]] = data[4:0];
         rd_sel = data[7:5];
      end
      e.taps = model;
      if (!addr[0]) e.rd = 8'h00;
      exp_q.push_back(e);
      phtap_master_i.xfer(addr, data, nbits, ack, rd);
      ack_seen = ack;
      rd_seen = addr[0] ? rd : 8'h00;
      -> xfer_done;
   endtask : send

   task automatic do_reset();
      reset_n = 1'b0;
      model = '0;
      rd_sel = 3'h0;
      repeat (5) @(posedge clk);
      #1 reset_n = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check("done", 40'h0, 40'(device_reset_done));
      check("taps", 40'h0, 40'(tap_select));
      send({1'b0, pins, 3'h0}, 8'h25, 8, 1'b0);
      check("done", 40'h1, 40'(device_reset_done));
   endtask : do_reset

   // ==========================================
   // Watcher: compares each finished transfer with its note
   initial begin : watch
      phtap_exp_s e;
      phtap_pkg::phtap_mode_s m, x;
      forever begin
         @(xfer_done);
         e = exp_q.pop_front();
         check("ack", 40'(e.ack), 40'(ack_seen));
         check("read", 40'(e.rd), 40'(rd_seen));
         check("taps", 40'(e.taps), 40'(tap_select));
         for (int c = 0; c < 5; c++) begin
            x = exp_mode(e.taps[c]);
            m = channel_mode[c];
            // Index is only meaningful while a tap is selected
            m.tap_index = m.tap_index & {5{x.tap_enable}};
            check("mode", 40'(x), 40'(m));
         end
      end
   end

   // ==========================================
   // Main sequence
   initial begin
      seed = 32'h79afce65;
      reset_n = 1'b0;
      r = $random(seed);
      pins = r[3:0];
      do_reset();
      send({1'b0, pins, 3'h1}, 8'h00, 8, 1'b1);
      for (int c = 0; c < 32; c++) begin
         r = $random(seed);
         sel = r[4:2] % 3'h5;
         send({1'b0, pins, r[1:0], 1'b0}, {sel, 5'(c)}, 8, 1'b1);
      end
      for (int c = 0; c < 5; c++) begin
         send({1'b0, pins, 3'h6}, {3'(c), 5'(24 - c)}, 8, 1'b1);
         send({1'b0, pins, 3'h3}, 8'h00, 8, 1'b1);
      end
      for (int s = 5; s < 8; s++) begin
         send({1'b0, pins, 3'h0}, {3'(s), 5'h07}, 8, 1'b1);
      end
      send({1'b0, pins, 3'h5}, 8'h00, 8, 1'b1);
      send({1'b1, pins, 3'h0}, 8'h4f, 8, 1'b1);
      r = $random(seed);
      send({1'b0, pins ^ (r[3:0] | 4'h1), 3'h2}, 8'h99, 8, 1'b1);
      send({1'b0, pins ^ 4'h8, 3'h1}, 8'h00, 8, 1'b1);
      send({1'b0, pins, 3'h0}, 8'h2a, 5, 1'b1);
      @(posedge clk);
      #1 pins = pins ^ 4'h5;
      repeat (4) @(posedge clk);
      send({1'b0, pins, 3'h4}, 8'h4f, 8, 1'b1);
      send({1'b0, pins, 3'h0}, 8'h99, 8, 1'b1);
      do_reset();
      send({1'b0, pins, 3'h0}, 8'h7b, 8, 1'b1);
      send({1'b0, pins, 3'h1}, 8'h00, 8, 1'b1);
      @(posedge clk);
      end_sim();
   end

   // ==========================================
   // Watchdog, well beyond the expected run length
   initial begin
      #400000;
      num_errors++;
      end_sim();
   end
endmodule : tb_top
